// file: hw/scan_pkg.sv
// Package with register map, field positions and types of the memory scanner
package scan_pkg;

  // Register byte addresses on the APB bus
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] cur_lo_off = 8'h04;
  localparam logic [7:0] cur_hi_off = 8'h08;
  localparam logic [7:0] end_lo_off = 8'h0C;
  localparam logic [7:0] end_hi_off = 8'h10;

  // Control register bit positions
  localparam int en_bit = 7;
  localparam int go_bit = 6;
  localparam int busy_bit = 5;
  localparam int invalid_bit = 4;
  localparam int interrupt_pause_select_bit = 3;
  localparam int mode_hi_bit = 1;
  localparam int mode_lo_bit = 0;

  // Values after reset
  localparam logic [15:0] addr_rst = 16'h0000;
  localparam logic [7:0] byte_rst = 8'h00;
  localparam logic [31:0] word_rst = 32'h0000_0000;

  // Access modes
  localparam logic [1:0] mode_concurrent = 2'h0;
  localparam logic [1:0] mode_burst = 2'h1;
  localparam logic [1:0] mode_peek = 2'h2;
  localparam logic [1:0] mode_triggered = 2'h3;

  // Scan engine states
  typedef enum logic [1:0] {st_idle, st_fetch, st_deliver} scan_state_t;

  // Fetch request towards program memory
  typedef struct packed {
    logic req;
    logic [15:0] addr;
  } fetch_req_t;

  // Word handed to the checksum engine
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sum_word_t;

endpackage : scan_pkg

// file: hw/nvm_scan_address_control.sv
// Program-memory scanner control and address tracking with an APB register slave
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Current address increments by one after every memory fetch of the scanner.
// - Current address pair is written as start and read back as fetch address.
// - Low byte register holds address bits 7:0, high byte bits 15:8.
// - Separate pair holds end address; high byte carries bits 15:8.
// - Address writes are discarded while scan-run request is one.
// - With interrupt pause select one, run request reads zero during interrupts, except in peek mode.
// - Address bits are read/write and clear to zero on every reset.
module nvm_scan_address_control #(
  parameter logic [15:0] mem_limit = 16'h4000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_active,
  input wire logic scan_trigger,
  output scan_pkg::fetch_req_t fetch,
  input wire logic fetch_ack,
  input wire logic [15:0] fetch_data,
  output scan_pkg::sum_word_t sum_word,
  input wire logic sum_ready,
  output logic scan_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic en_r;
  logic go_r;
  logic busy_r;
  logic invalid_r;
  logic interrupt_pause_select_r;
  logic [1:0] mode_r;
  logic [15:0] cur_addr_r;
  logic [15:0] end_addr_r;
  logic trig_pend_r;
  scan_pkg::scan_state_t state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  scan_pkg::fetch_req_t fetch_r;
  scan_pkg::sum_word_t sum_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic addr_wr_ok;
  logic mapped;
  logic paused;
  logic go_eff;
  logic scan_done;
  logic fetch_fire;
  logic start_fetch;
  logic [7:0] ctrl_view;

  // Access completes in the second access cycle
  assign acc = psel && penable && pready_r;
  assign wr = acc && pwrite;
  assign wr_ctrl = wr && (paddr == scan_pkg::ctrl_off);
  assign addr_wr_ok = wr && !go_r;
  assign mapped = (paddr == scan_pkg::ctrl_off) || (paddr == scan_pkg::cur_lo_off) ||
                  (paddr == scan_pkg::cur_hi_off) || (paddr == scan_pkg::end_lo_off) ||
                  (paddr == scan_pkg::end_hi_off);

  // Interrupt pause, ignored in peek mode
  assign paused = interrupt_pause_select_r && irq_active && (mode_r != scan_pkg::mode_peek);
  assign go_eff = go_r && !paused;

  // Control register image
  always_comb
  begin
    ctrl_view = scan_pkg::byte_rst;
    ctrl_view[scan_pkg::en_bit] = en_r;
    ctrl_view[scan_pkg::go_bit] = go_eff;
    ctrl_view[scan_pkg::busy_bit] = busy_r;
    ctrl_view[scan_pkg::invalid_bit] = invalid_r;
    ctrl_view[scan_pkg::interrupt_pause_select_bit] = interrupt_pause_select_r;
    ctrl_view[scan_pkg::mode_hi_bit:scan_pkg::mode_lo_bit] = mode_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencing conditions
  assign scan_done = (cur_addr_r > end_addr_r);
  assign fetch_fire = (state_r == scan_pkg::st_fetch) && fetch_ack;

  // Triggered mode needs a pending trigger; peek waits for the checksum side
  always_comb
  begin
    case (mode_r)
      scan_pkg::mode_triggered: start_fetch = trig_pend_r;
      scan_pkg::mode_peek: start_fetch = sum_ready;
      scan_pkg::mode_burst: start_fetch = 1'b1;
      scan_pkg::mode_concurrent: start_fetch = 1'b1;
      default: start_fetch = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= scan_pkg::word_rst;
    end
    else
    begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      prdata_r <= scan_pkg::word_rst;
      if (psel && penable && !pready_r && !pwrite)
      begin
        case (paddr)
          scan_pkg::ctrl_off: prdata_r[7:0] <= ctrl_view;
          scan_pkg::cur_lo_off: prdata_r[7:0] <= cur_addr_r[7:0];
          scan_pkg::cur_hi_off: prdata_r[7:0] <= cur_addr_r[15:8];
          scan_pkg::end_lo_off: prdata_r[7:0] <= end_addr_r[7:0];
          scan_pkg::end_hi_off: prdata_r[7:0] <= end_addr_r[15:8];
          default: prdata_r <= scan_pkg::word_rst;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control fields written by software
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      en_r <= 1'b0;
      interrupt_pause_select_r <= 1'b0;
      mode_r <= scan_pkg::mode_concurrent;
    end
    else if (wr_ctrl)
    begin
      en_r <= pwdata[scan_pkg::en_bit];
      interrupt_pause_select_r <= pwdata[scan_pkg::interrupt_pause_select_bit];
      mode_r <= pwdata[scan_pkg::mode_hi_bit:scan_pkg::mode_lo_bit];
    end
  end

  // Run request: software sets, hardware clears at scan end or on invalid address
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      go_r <= 1'b0;
    else if (wr_ctrl)
      go_r <= pwdata[scan_pkg::go_bit] && pwdata[scan_pkg::en_bit];
    else if (!en_r)
      go_r <= 1'b0;
    else if (state_r == scan_pkg::st_idle && go_eff && (scan_done || cur_addr_r >= mem_limit))
      go_r <= 1'b0;
  end

  // Invalid address flag, cleared by a fresh start
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      invalid_r <= 1'b0;
    else if (state_r == scan_pkg::st_idle && go_eff && !scan_done && cur_addr_r >= mem_limit)
      invalid_r <= 1'b1;
    else if (wr_ctrl && pwdata[scan_pkg::go_bit])
      invalid_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current address: written as start, advanced per fetch
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cur_addr_r <= scan_pkg::addr_rst;
    else if (fetch_fire)
      cur_addr_r <= cur_addr_r + 16'h0001;
    else if (addr_wr_ok && paddr == scan_pkg::cur_lo_off)
      cur_addr_r[7:0] <= pwdata[7:0];
    else if (addr_wr_ok && paddr == scan_pkg::cur_hi_off)
      cur_addr_r[15:8] <= pwdata[7:0];
  end

  // End address pair
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      end_addr_r <= scan_pkg::addr_rst;
    else if (addr_wr_ok && paddr == scan_pkg::end_lo_off)
      end_addr_r[7:0] <= pwdata[7:0];
    else if (addr_wr_ok && paddr == scan_pkg::end_hi_off)
      end_addr_r[15:8] <= pwdata[7:0];
  end

  // Trigger catch; a new trigger wins over consumption
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trig_pend_r <= 1'b0;
    else if (scan_trigger)
      trig_pend_r <= 1'b1;
    else if (state_r == scan_pkg::st_idle && go_eff && start_fetch && !scan_done)
      trig_pend_r <= 1'b0;
    else if (!go_r)
      trig_pend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch and delivery engine
  always_ff @(posedge clk)
  begin
    if (!rst_n || !en_r)
    begin
      state_r <= scan_pkg::st_idle;
      busy_r <= 1'b0;
      fetch_r <= '0;
      sum_r <= '0;
    end
    else
    begin
      case (state_r)
        scan_pkg::st_idle:
        begin
          busy_r <= 1'b0;
          if (go_eff && !scan_done && cur_addr_r < mem_limit && start_fetch)
          begin
            state_r <= scan_pkg::st_fetch;
            busy_r <= 1'b1;
            fetch_r.req <= 1'b1;
            fetch_r.addr <= cur_addr_r;
          end
        end
        scan_pkg::st_fetch:
        begin
          if (fetch_ack)
          begin
            fetch_r.req <= 1'b0;
            sum_r.valid <= 1'b1;
            sum_r.data <= fetch_data;
            state_r <= scan_pkg::st_deliver;
          end
        end
        scan_pkg::st_deliver:
        begin
          if (sum_ready)
          begin
            sum_r.valid <= 1'b0;
            state_r <= scan_pkg::st_idle;
          end
        end
        default: state_r <= scan_pkg::st_idle;
      endcase
    end
  end

  // Output drive
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fetch = fetch_r;
  assign sum_word = sum_r;
  assign scan_busy = busy_r;

endmodule : nvm_scan_address_control

// file: bench/scan_memory_model.sv
// Memory and checksum engine model facing the scanner
`timescale 1ns/1ps
module scan_memory_model (
  input wire logic clk,
  input wire logic rst_n,
  input scan_pkg::fetch_req_t fetch,
  output logic fetch_ack,
  output logic [15:0] fetch_data,
  input scan_pkg::sum_word_t sum_word,
  output logic sum_ready,
  output int words,
  output int bad
);
  int wait_cnt;
  logic [15:0] taken_addr;
  // Slow answer, stalling checksum side, count of words taken and of wrong data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wait_cnt <= 0;
      fetch_ack <= 1'b0;
      sum_ready <= 1'b0;
      words <= 0;
      bad <= 0;
      taken_addr <= 16'h0000;
    end
    else
    begin
      sum_ready <= !sum_ready;
      fetch_ack <= fetch.req && !fetch_ack && wait_cnt == 3;
      wait_cnt <= (fetch.req && !fetch_ack) ? wait_cnt + 1 : 0;
      if (fetch_ack)
        taken_addr <= fetch.addr;
      if (sum_word.valid && sum_ready)
        words <= words + 1;
      if (sum_word.valid && sum_ready && sum_word.data != ~taken_addr)
        bad <= bad + 1;
    end
  end
  // Data only valid with the acknowledge
  assign fetch_data = fetch_ack ? ~fetch.addr : {8'hA5, 8'(wait_cnt)};
endmodule : scan_memory_model

// file: bench/scan_checker_properties.sv
// Timing checks on the scanner's bus and fetch ports
`timescale 1ns/1ps
module scan_checker (
  input logic clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input scan_pkg::fetch_req_t fetch,
  input logic fetch_ack,
  input logic [15:0] fetch_data,
  input scan_pkg::sum_word_t sum_word,
  input logic sum_ready,
  input logic scan_busy
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence fetch_done;
    fetch.req && fetch_ack;
  endsequence
  sequence word_held;
    sum_word.valid && $stable(sum_word.data);
  endsequence
  ready_latency_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  upper_bits_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("prdata upper bits set");
  fetch_hold_a: assert property (fetch.req && !fetch_ack && !pready |=> fetch.req)
    else $error("fetch dropped");
  fetch_result_a: assert property (fetch_done |=> !fetch.req ##0 sum_word.valid)
    else $error("fetch not delivered");
  word_data_a: assert property (fetch_done |=> sum_word.data == $past(fetch_data))
    else $error("word data wrong");
  word_hold_a: assert property (sum_word.valid && !sum_ready && !pready |=> word_held)
    else $error("word dropped");
  busy_fetch_a: assert property (fetch.req |-> scan_busy)
    else $error("busy low in fetch");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> !pready && !fetch.req)
    else $error("outputs not cleared");
endmodule : scan_checker
bind nvm_scan_address_control scan_checker scan_checker_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fetch(fetch), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .sum_word(sum_word),
  .sum_ready(sum_ready), .scan_busy(scan_busy));

// file: bench/nvm_scan_address_control_tb.sv
// Register-level bench of the scanner address control
`timescale 1ns/1ps
module nvm_scan_address_control_tb;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_active, fetch_ack, sum_ready;
  logic scan_busy, e, scan_trigger;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] fetch_data;
  scan_pkg::fetch_req_t fetch;
  scan_pkg::sum_word_t sum_word;
  int err_count, checked, words, bad;
  nvm_scan_address_control nvm_scan_address_control_inst (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_active(irq_active),
    .scan_trigger(scan_trigger), .fetch(fetch), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .sum_word(sum_word), .sum_ready(sum_ready), .scan_busy(scan_busy));
  scan_memory_model scan_memory_model_inst (.clk(clk), .rst_n(rst_n), .fetch(fetch),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .sum_word(sum_word),
    .sum_ready(sum_ready), .words(words), .bad(bad));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic limit(input int n);
    if (n > 60)
    begin
      err_count++;
      $display("wrong value at %0t: wait limit reached", $time);
      results();
    end
  endtask : limit
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
      n++;
      limit(n);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(a, 1'b0, 32'h0);
    check(q, x);
  endtask : rd
  task automatic wait_idle;
    int n;
    n = 0;
    q = 32'hFF;
    while (q[scan_pkg::go_bit] !== 1'b0)
    begin
      apb(scan_pkg::ctrl_off, 1'b0, 32'h0);
      n++;
      limit(n);
    end
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, irq_active, scan_trigger} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    for (int i = 1; i < 5; i++)
    begin
      apb(8'(4 * i), 1'b1, 32'hFF);
      rd(8'(4 * i), 32'hFF);
    end
    apb(8'h14, 1'b1, 32'h1);
    check({31'h0, e}, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      apb(scan_pkg::ctrl_off, 1'b1, 32'h88 | m);
      rd(scan_pkg::ctrl_off, 32'h88 | m);
    end
    apb(scan_pkg::ctrl_off, 1'b1, 32'h0);
    apb(scan_pkg::cur_lo_off, 1'b1, 32'h02);
    apb(scan_pkg::cur_hi_off, 1'b1, 32'h01);
    apb(scan_pkg::end_lo_off, 1'b1, 32'h04);
    apb(scan_pkg::end_hi_off, 1'b1, 32'h01);
    rd(scan_pkg::cur_lo_off, 32'h02);
    rd(scan_pkg::cur_hi_off, 32'h01);
    rd(scan_pkg::end_hi_off, 32'h01);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hC0);
    apb(scan_pkg::cur_lo_off, 1'b1, 32'h55);
    apb(scan_pkg::end_hi_off, 1'b1, 32'h7F);
    wait_idle();
    rd(scan_pkg::cur_lo_off, 32'h05);
    rd(scan_pkg::cur_hi_off, 32'h01);
    rd(scan_pkg::end_hi_off, 32'h01);
    check(words, 32'h3);
    // Pause while an interrupt is serviced, then resume
    irq_active <= 1'b1;
    apb(scan_pkg::cur_lo_off, 1'b1, 32'h00);
    apb(scan_pkg::cur_hi_off, 1'b1, 32'h02);
    apb(scan_pkg::end_hi_off, 1'b1, 32'h02);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hC8);
    apb(scan_pkg::ctrl_off, 1'b0, 32'h0);
    check({31'h0, q[scan_pkg::go_bit]}, 32'h0);
    rd(scan_pkg::cur_lo_off, 32'h00);
    irq_active <= 1'b0;
    wait_idle();
    rd(scan_pkg::cur_lo_off, 32'h05);
    // Peek mode keeps scanning through an interrupt
    irq_active <= 1'b1;
    apb(scan_pkg::cur_lo_off, 1'b1, 32'h00);
    apb(scan_pkg::cur_hi_off, 1'b1, 32'h03);
    apb(scan_pkg::end_hi_off, 1'b1, 32'h03);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hCA);
    apb(scan_pkg::ctrl_off, 1'b0, 32'h0);
    check({31'h0, q[scan_pkg::go_bit]}, 32'h1);
    wait_idle();
    rd(scan_pkg::cur_lo_off, 32'h05);
    check(bad, 32'h0);
    // Interrupts leave the run bit alone without pause select; reset mid-scan
    apb(scan_pkg::end_hi_off, 1'b1, 32'h04);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hC0);
    apb(scan_pkg::ctrl_off, 1'b0, 32'h0);
    check({31'h0, q[scan_pkg::go_bit]}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    // Triggered mode fetches one word per trigger pulse
    apb(scan_pkg::end_lo_off, 1'b1, 32'h01);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hC3);
    rd(scan_pkg::cur_lo_off, 32'h00);
    scan_trigger <= 1'b1;
    @(posedge clk);
    scan_trigger <= 1'b0;
    repeat (12) @(posedge clk);
    rd(scan_pkg::cur_lo_off, 32'h01);
    scan_trigger <= 1'b1;
    @(posedge clk);
    scan_trigger <= 1'b0;
    wait_idle();
    rd(scan_pkg::cur_lo_off, 32'h02);
    check(words, 32'h2);
    check(bad, 32'h0);
    // Start address beyond memory: no fetch, invalid flag, run cleared
    apb(scan_pkg::cur_hi_off, 1'b1, 32'h40);
    apb(scan_pkg::end_hi_off, 1'b1, 32'h41);
    apb(scan_pkg::ctrl_off, 1'b1, 32'hC0);
    wait_idle();
    check(q, 32'h90);
    rd(scan_pkg::cur_hi_off, 32'h40);
    results();
  end
endmodule : nvm_scan_address_control_tb
